// ---- hdl/sacp_pkg.sv ----
// Purpose: Constants and types shared by both ends of the serial ADC port
// Assumes: One system clock mclk at 100 MHz, synchronous active-high reset
// Notes:   Link clock made by the host end by dividing mclk
package sacp_pkg;
    localparam int RES_W      = 10;
    localparam int CTRL_BITS  = 4;
    localparam int FRAME_CLKS = 16;
    localparam int CNT_W      = 5;
    localparam int FIFO_W     = 10;
    localparam int FIFO_D     = 32;
    // Half link period; outlasts both synchroniser lags
    localparam int SCLK_HALF  = 8;
    localparam int MCLK_MHZ   = 100;
    localparam logic [3:0] CTRL_WORD_BASE = 4'h_d;
    localparam logic [3:0] CTRL_ODD_MASK  = 4'h_2;

    typedef enum logic [2:0] {
        SACP_IDLE  = 3'b000,
        SACP_SEL   = 3'b001,
        SACP_CTRL  = 3'b011,
        SACP_READ  = 3'b010,
        SACP_DONE  = 3'b110
    } sacp_state_t;
endpackage : sacp_pkg

// ---- hdl/sacp_link_if.sv ----
// Purpose: Three-wire serial link between host and converter
// Assumes: Data wire shared by both ends, resolved here
// Notes:   Wire pulled low when nobody drives it
`timescale 1ns/10ps
`default_nettype none
interface sacp_link_if;
    logic cs_n;
    logic sclk;
    logic host_do;
    logic host_oe;
    logic dev_do;
    logic dev_oe;
    logic data;

    assign data = host_oe ? host_do : (dev_oe ? dev_do : 1'b0);

    modport dev  (input cs_n, input sclk, input data,
                  output dev_do, output dev_oe);
    modport host (output cs_n, output sclk, output host_do,
                  output host_oe, input data);
endinterface : sacp_link_if
`default_nettype wire

// ---- hdl/sacp_fifo.sv ----
// Purpose: Parameterised flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Honest full and empty
`timescale 1ns/10ps
`default_nettype none
module sacp_fifo #(
    parameter int W = 10,
    parameter int D = 32
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
    logic         push, pop;

    assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule : sacp_fifo
`default_nettype wire

// ---- hdl/sacp_dev.sv ----
// Purpose: Converter end: captures control word, shifts out result
// Assumes: cs_n and sclk sampled by mclk through two flip-flops
// Notes:   Sample input is a user-side port per channel
`timescale 1ns/10ps
`default_nettype none
module sacp_dev
    import sacp_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             reset,
    sacp_link_if.dev              link,
    input  wire logic [RES_W-1:0] chan0_sample,
    input  wire logic [RES_W-1:0] chan1_sample,
    output logic                  shutdown,
    output logic                  sel_chan
);
    logic [1:0]       cs_s_r, ck_s_r, dt_s_r;
    logic             ck_d_r;
    logic             started_r, started_nxt;
    logic [1:0]       ctl_n_r, ctl_n_nxt;
    logic             chan_r, chan_nxt;
    logic [CNT_W-1:0] bit_r, bit_nxt;
    logic [RES_W-1:0] res_r, res_nxt;
    logic             do_r, do_nxt, oe_r, oe_nxt, sd_r, sd_nxt;
    logic             rise, fall, cs_lo;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cs_s_r <= 2'b11;
            ck_s_r <= '0;
            dt_s_r <= '0;
            ck_d_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[0], link.cs_n};
            ck_s_r <= {ck_s_r[0], link.sclk};
            dt_s_r <= {dt_s_r[0], link.data};
            ck_d_r <= ck_s_r[1];
        end
    end
    assign rise  = ck_s_r[1] && !ck_d_r;
    assign fall  = !ck_s_r[1] && ck_d_r;
    assign cs_lo = !cs_s_r[1];

    always_comb begin
        started_nxt = started_r;
        ctl_n_nxt   = ctl_n_r;
        chan_nxt    = chan_r;
        bit_nxt     = bit_r;
        res_nxt     = res_r;
        do_nxt      = do_r;
        oe_nxt      = oe_r;
        sd_nxt      = sd_r;
        if (!cs_lo) begin
            started_nxt = 1'b0;
            ctl_n_nxt   = '0;
            bit_nxt     = '0;
            oe_nxt      = 1'b0;
            do_nxt      = 1'b0;
        end else if (rise && !started_r) begin
            started_nxt = dt_s_r[1];
            sd_nxt      = !dt_s_r[1] && sd_r;
        end else if (rise && ctl_n_r < 2'd3) begin
            ctl_n_nxt = ctl_n_r + 2'd1;
            if (ctl_n_r == 2'd1) begin
                chan_nxt = dt_s_r[1];
            end
            if (ctl_n_r == 2'd2) begin
                res_nxt = chan_r ? chan1_sample : chan0_sample;
                sd_nxt  = 1'b0;
            end
        end else if (fall && ctl_n_r == 2'd3) begin
            oe_nxt = 1'b1;
            if (bit_r == '0) begin
                do_nxt = 1'b0;
                bit_nxt = bit_r + 1'b1;
            end else if (bit_r <= CNT_W'(RES_W)) begin
                do_nxt  = res_r[RES_W-1];
                res_nxt = {res_r[RES_W-2:0], 1'b0};
                bit_nxt = bit_r + 1'b1;
                if (bit_r == CNT_W'(RES_W)) begin
                    sd_nxt = 1'b1;
                end
            end else begin
                do_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            started_r <= 1'b0;
            ctl_n_r   <= '0;
            chan_r    <= 1'b0;
            bit_r     <= '0;
            res_r     <= '0;
            do_r      <= 1'b0;
            oe_r      <= 1'b0;
            sd_r      <= 1'b1;
        end else begin
            started_r <= started_nxt;
            ctl_n_r   <= ctl_n_nxt;
            chan_r    <= chan_nxt;
            bit_r     <= bit_nxt;
            res_r     <= res_nxt;
            do_r      <= do_nxt;
            oe_r      <= oe_nxt;
            sd_r      <= sd_nxt;
        end
    end

    assign link.dev_do = do_r;
    assign link.dev_oe = oe_r;
    assign shutdown    = sd_r;
    assign sel_chan    = chan_r;
endmodule : sacp_dev
`default_nettype wire

// ---- hdl/sacp_host.sv ----
// Purpose: Host end: frames conversions, reads results into a FIFO
// Assumes: Makes sclk by dividing mclk
// Notes:   Results leave through a 32-word FIFO
`timescale 1ns/10ps
`default_nettype none
module sacp_host
    import sacp_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             reset,
    sacp_link_if.host             link,
    input  wire logic             start,
    input  wire logic             chan,
    output logic                  busy,
    output logic [RES_W-1:0]      res_data,
    output logic                  res_valid,
    input  wire logic             res_ready
);
    sacp_state_t      st_r, st_nxt;
    logic [2:0]       div_r, div_nxt;
    logic             ck_r, ck_nxt, cs_r, cs_nxt;
    logic             do_r, do_nxt, oe_r, oe_nxt;
    logic [CNT_W-1:0] n_r, n_nxt;
    logic [3:0]       ctl_r, ctl_nxt;
    logic [RES_W-1:0] sh_r, sh_nxt;
    logic [1:0]       dt_s_r;
    logic             push, f_rdy, tick;
    logic             busy_r, busy_nxt;

    assign tick = div_r == 3'(SCLK_HALF - 1);

    always_comb begin
        st_nxt  = st_r;
        div_nxt = tick ? 3'd0 : div_r + 3'd1;
        ck_nxt  = ck_r;
        cs_nxt  = cs_r;
        do_nxt  = do_r;
        oe_nxt  = oe_r;
        n_nxt   = n_r;
        ctl_nxt = ctl_r;
        sh_nxt  = sh_r;
        push    = 1'b0;
        unique case (st_r)
            SACP_IDLE: begin
                cs_nxt = 1'b1;
                ck_nxt = 1'b0;
                oe_nxt = 1'b0;
                if (start && f_rdy && tick) begin
                    ctl_nxt = chan ? (CTRL_WORD_BASE | CTRL_ODD_MASK)
                                   : (CTRL_WORD_BASE & ~CTRL_ODD_MASK);
                    st_nxt  = SACP_SEL;
                end
            end
            SACP_SEL: if (tick) begin
                cs_nxt = 1'b0;
                n_nxt  = '0;
                st_nxt = SACP_CTRL;
            end
            SACP_CTRL: if (tick) begin
                if (!ck_r && !oe_r) begin
                    do_nxt  = ctl_r[3];
                    oe_nxt  = 1'b1;
                    ctl_nxt = {ctl_r[2:0], 1'b0};
                end else if (!ck_r) begin
                    ck_nxt = 1'b1;
                end else begin
                    // Next bit placed on the falling edge
                    ck_nxt  = 1'b0;
                    n_nxt   = n_r + 1'b1;
                    do_nxt  = ctl_r[3];
                    ctl_nxt = {ctl_r[2:0], 1'b0};
                    if (n_r == CNT_W'(CTRL_BITS - 1)) begin
                        oe_nxt = 1'b0;
                        n_nxt  = '0;
                        st_nxt = SACP_READ;
                    end
                end
            end
            SACP_READ: if (tick) begin
                if (!ck_r) begin
                    ck_nxt = 1'b1;
                    if (n_r != '0) sh_nxt = {sh_r[RES_W-2:0], dt_s_r[1]};
                end else begin
                    ck_nxt = 1'b0;
                    n_nxt  = n_r + 1'b1;
                    if (n_r == CNT_W'(RES_W)) st_nxt = SACP_DONE;
                end
            end
            SACP_DONE: if (tick) begin
                cs_nxt = 1'b1;
                push   = 1'b1;
                st_nxt = SACP_IDLE;
            end
            default: st_nxt = SACP_IDLE;
        endcase
        busy_nxt = st_nxt != SACP_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r   <= SACP_IDLE;
            div_r  <= '0;
            ck_r   <= 1'b0;
            cs_r   <= 1'b1;
            do_r   <= 1'b0;
            oe_r   <= 1'b0;
            n_r    <= '0;
            ctl_r  <= '0;
            sh_r   <= '0;
            dt_s_r <= '0;
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            st_r   <= st_nxt;
            div_r  <= div_nxt;
            ck_r   <= ck_nxt;
            cs_r   <= cs_nxt;
            do_r   <= do_nxt;
            oe_r   <= oe_nxt;
            n_r    <= n_nxt;
            ctl_r  <= ctl_nxt;
            sh_r   <= sh_nxt;
            dt_s_r <= {dt_s_r[0], link.data};
        end
    end

    sacp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_data   (sh_r),
        .in_valid  (push),
        .in_ready  (f_rdy),
        .out_data  (res_data),
        .out_valid (res_valid),
        .out_ready (res_ready)
    );

    assign link.cs_n    = cs_r;
    assign link.sclk    = ck_r;
    assign link.host_do = do_r;
    assign link.host_oe = oe_r;
    assign busy         = busy_r;
endmodule : sacp_host
`default_nettype wire

// ---- sim/sacp_link_monitor.sv ----
// Purpose: Watches the shared serial link between the two ends
// Assumes: Single mclk domain, synchronous active-high reset
// Notes:   Counts link clock rises within each frame
`timescale 1ns/10ps
`default_nettype none
module sacp_link_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_do,
    input wire logic host_oe,
    input wire logic dev_do,
    input wire logic dev_oe,
    input wire logic data
);
    logic [4:0] rise_r;
    logic [4:0] rise_nxt;
    logic       sclk_r;
    logic       sclk_nxt;

    always_comb begin
        sclk_nxt = sclk;
        rise_nxt = rise_r;
        if (cs_n) begin
            rise_nxt = 5'h0;
        end else if (sclk && !sclk_r) begin
            rise_nxt = rise_r + 5'h1;
        end
    end

    always_ff @(posedge mclk) begin
        sclk_r <= reset ? 1'b0 : sclk_nxt;
        rise_r <= reset ? 5'h0 : rise_nxt;
    end

    // ****************************************
    // Link checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_open; cs_n ##1 !cs_n; endsequence
    sequence s_rise; !sclk ##1 sclk; endsequence

    chk_no_clash: assert property (!(host_oe && dev_oe))
        else $error("both ends drive data");
    chk_cs_open: assert property (s_open |-> !sclk && !dev_oe)
        else $error("frame opened with clock high");
    chk_start_bit: assert property (s_rise ##0 rise_r == 5'h0
        |-> host_oe && data) else $error("start bit missing");
    chk_ctrl_fixed: assert property (s_rise ##0 rise_r inside {1, 3}
        |-> host_oe && data) else $error("control bit wrong");
    chk_host_release: assert property (s_rise ##0 rise_r >= 5'h4
        |-> !host_oe) else $error("host drives during readout");
    chk_dev_drives: assert property (s_rise ##0 rise_r >= 5'h4
        |-> dev_oe && data == dev_do)
        else $error("device silent in readout");
    chk_null_lead: assert property (s_rise ##0 rise_r == 5'h4
        |-> !data) else $error("leading bit not zero");
    chk_frame_len: assert property ($rose(cs_n) |-> rise_r == 5'hf)
        else $error("wrong clock count in frame");
    chk_ctrl_hold: assert property (sclk && $past(sclk) && host_oe
        |-> $stable(host_do)) else $error("data moved while clock high");
    chk_sclk_half: assert property ($rose(sclk) |-> sclk[*4])
        else $error("link clock high too short");
    chk_dev_float: assert property (cs_n[*6] |-> !dev_oe)
        else $error("device drives while deselected");
endmodule : sacp_link_monitor
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench joining host and converter ends
// Assumes: mclk 100 MHz, reset held 16 cycles
// Notes:   Link traffic captured at each link clock rise
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sacp_pkg::*;
;
    logic             mclk;
    logic             reset;
    logic             start;
    logic             chan;
    logic             res_ready;
    logic             busy;
    logic             res_valid;
    logic             shutdown;
    logic             sel_chan;
    logic [RES_W-1:0] res_data;
    logic [RES_W-1:0] chan0_sample;
    logic [RES_W-1:0] chan1_sample;
    logic [14:0]      cap;
    logic [RES_W-1:0] vals [4] = '{10'h249, 10'h2b6, 10'h3ff, 10'h000};
    int               err_count;
    int               check_count;
    int               cyc;

    sacp_link_if link();
    sacp_host u_sacp_host (.mclk(mclk), .reset(reset), .link(link),
        .start(start), .chan(chan), .busy(busy), .res_data(res_data),
        .res_valid(res_valid), .res_ready(res_ready));
    sacp_dev u_sacp_dev (.mclk(mclk), .reset(reset), .link(link),
        .chan0_sample(chan0_sample), .chan1_sample(chan1_sample),
        .shutdown(shutdown), .sel_chan(sel_chan));
    sacp_link_monitor u_sacp_link_monitor (.mclk(mclk), .reset(reset),
        .cs_n(link.cs_n), .sclk(link.sclk), .host_do(link.host_do),
        .host_oe(link.host_oe), .dev_do(link.dev_do),
        .dev_oe(link.dev_oe), .data(link.data));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Wire capture of every bit in a frame
    always @(posedge link.sclk) begin
        if (!link.cs_n) cap = {cap[13:0], link.data};
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic frame(input logic ch, input logic [RES_W-1:0] v);
        int n;
        n = 0;
        cap = 15'h0;
        @(posedge mclk);
        chan0_sample <= ch ? ~v : v;
        chan1_sample <= ch ? v : ~v;
        start        <= 1'b1;
        chan         <= ch;
        do @(negedge mclk); while (busy !== 1'b1 && ++n < 50);
        cmp({14'h0, busy}, 15'h1);
        @(posedge mclk);
        start <= 1'b0;
        repeat (12 * SCLK_HALF) @(negedge mclk);
        cmp({14'h0, shutdown}, 15'h0);
        do @(negedge mclk); while (busy !== 1'b0 && ++n < 600);
        cmp({14'h0, busy}, 15'h0);
        cmp(cap, {CTRL_WORD_BASE | (ch ? CTRL_ODD_MASK : 4'h0), 1'b0, v});
        cmp({14'h0, sel_chan}, {14'h0, ch});
        cmp({14'h0, shutdown}, 15'h1);
    endtask : frame

    task automatic pop(input logic [RES_W-1:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        while (res_valid !== 1'b1 && n++ < 400) @(negedge mclk);
        cmp({14'h0, res_valid}, 15'h1);
        cmp({5'h0, res_data}, {5'h0, e});
        @(posedge mclk);
        res_ready <= 1'b1;
        @(posedge mclk);
        res_ready <= 1'b0;
    endtask : pop

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        reset        = 1'b1;
        start        = 1'b0;
        chan         = 1'b0;
        res_ready    = 1'b0;
        chan0_sample = 10'h0;
        chan1_sample = 10'h0;
        cap          = 15'h0;
        err_count    = 0;
        check_count  = 0;
        cyc          = 0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            frame(i[0], vals[i]);
            pop(vals[i]);
        end
        $display("test basic done");
        for (int i = 0; i < FIFO_D; i++) frame(i[0], vals[i % 4]);
        @(posedge mclk);
        start <= 1'b1;
        repeat (300) @(negedge mclk);
        cmp({14'h0, busy}, 15'h0);
        @(posedge mclk);
        start <= 1'b0;
        for (int i = 0; i < FIFO_D; i++) pop(vals[i % 4]);
        @(negedge mclk);
        cmp({14'h0, res_valid}, 15'h0);
        $display("test fill done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
